/* rtl/ir_pkg.sv */
// constants, types and behaviour summary for the infrared transcoder
// How it works
// - first input decodes only standard-format frames
// - second input decodes standard when select high, extended when low
// - input whose falling edge comes first is decoded alone
// - frames with bad biphase, start or stop are dropped
// - first start bit only triggers; frame ends after 1.5 idle bit-times
// - bit-time is 128 oscillator periods standard, 64 extended
// - standard word: valid, format, input, control, 5 address, 6 command
// - extended word: valid, format, input, 3 master, 8 control, slave, data
// - standby set only acts while standby gate is high
// - standby set low raises power-off and allows buffer overwrite
// - standard word entering buffer drops power-off
// - extended word drops power-off on reset-standby bit and master match
// - reset forces power-off low
// - valid output follows buffer; new word dropped if full or busy
// - reset forces valid output low
// - buffer word leaves on the bus leftmost bit first
// - read-only slave transmitter at fixed address 0100110
// - write address gets no acknowledge, line left high until stop
// - master no-acknowledge releases line until stop
// - after the last bit the line stays high until stop
package ir_pkg;
    localparam logic [6:0] SLAVE_ADDR      = 7'h26;
    localparam int         OSC_PER_BIT_STD = 128;
    localparam int         OSC_PER_BIT_EXT = 64;
    localparam logic [6:0] QTR_STD_M1      = 7'(OSC_PER_BIT_STD / 4 - 1);
    localparam logic [6:0] QTR_EXT_M1      = 7'(OSC_PER_BIT_EXT / 4 - 1);
    localparam int         N_STD           = 13;
    localparam int         N_EXT           = 27;
    localparam int         STOP_QTRS       = 6;
    localparam logic [7:0] QEND_STD        = 8'(4 * N_STD + 2 + STOP_QTRS);
    localparam logic [7:0] QEND_EXT        = 8'(4 * N_EXT + 2 + STOP_QTRS);
    localparam logic [7:0] QSTOP_STD       = 8'(4 * N_STD + 3);
    localparam logic [7:0] QSTOP_EXT       = 8'(4 * N_EXT + 3);
    localparam logic [7:0] Q_FIRST_B       = 8'h05;
    localparam logic [2:0] BYTES_STD       = 3'h2;
    localparam logic [2:0] BYTES_EXT       = 3'h4;
    localparam logic [2:0] LD_IDLE         = 3'h7;
    localparam int         RSB_POS         = 16;
    localparam int         MA_LSB          = 24;
    localparam int         FIFO_W          = 8;
    localparam int         FIFO_D          = 2;
    localparam int         FIFO_AW         = 1;
    localparam logic [1:0] FIFO_FULL       = 2'(FIFO_D);
    // synchronised pin vector positions
    localparam int P_MA0 = 0;
    localparam int P_MA2 = 2;
    localparam int P_SET = 3;
    localparam int P_GATE = 4;
    localparam int P_FSEL = 5;
    localparam int P_D2 = 6;
    localparam int P_D1 = 7;
    localparam int P_OSC = 8;
    localparam int P_SDA = 9;
    localparam int P_SCL = 10;
    localparam int NPIN = 11;

    typedef enum logic [1:0] {D_IDLE = 2'h1, D_RUN = 2'h2} dec_state_t;
    typedef enum logic [5:0] {
        I_IDLE = 6'h01, I_ADDR = 6'h02, I_AACK = 6'h04,
        I_TX = 6'h08, I_MACK = 6'h10, I_WAIT = 6'h20
    } i2c_state_t;
endpackage

/* rtl/ir_transcoder.sv */
// biphase decoder, code buffer and two-wire read-only slave
`timescale 1ns/100ps
module ir_transcoder
    import ir_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic data1_i,
    input  wire logic data2_i,
    input  wire logic format_select_in_i,
    input  wire logic master_addr_in0_i,
    input  wire logic master_addr_in1_i,
    input  wire logic master_addr_in2_i,
    input  wire logic standby_gate_in_i,
    input  wire logic standby_set_in_i,
    input  wire logic osc_in_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      osc_out_o,
    output logic      sda_o,
    output logic      sda_oe_n_o,
    output logic      buffer_valid_out_o,
    output logic      power_off_out_o
);
    // ==========================================
    // reset and pin synchronisers
    logic            rst_meta_ff, rst_n_ff;
    logic [NPIN-1:0] meta_ff, pin_ff, prev_ff;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            meta_ff <= '1;
            pin_ff  <= '1;
            prev_ff <= '1;
        end else begin
            meta_ff <= {scl_i, sda_i, osc_in_i, data1_i, data2_i, format_select_in_i,
                        standby_gate_in_i, standby_set_in_i, master_addr_in2_i,
                        master_addr_in1_i, master_addr_in0_i};
            pin_ff  <= meta_ff;
            prev_ff <= pin_ff;
        end
    end
    logic osc_rise, fall1, fall2, scl_rise, scl_fall, start_c, stop_c;
    assign osc_rise = pin_ff[P_OSC] & ~prev_ff[P_OSC];
    assign fall1    = ~pin_ff[P_D1] & prev_ff[P_D1];
    assign fall2    = ~pin_ff[P_D2] & prev_ff[P_D2];
    assign scl_rise = pin_ff[P_SCL] & ~prev_ff[P_SCL];
    assign scl_fall = ~pin_ff[P_SCL] & prev_ff[P_SCL];
    assign start_c  = pin_ff[P_SCL] & prev_ff[P_SCL] & ~pin_ff[P_SDA] & prev_ff[P_SDA];
    assign stop_c   = pin_ff[P_SCL] & prev_ff[P_SCL] & pin_ff[P_SDA] & ~prev_ff[P_SDA];

    logic osc_out_ff;
    always_ff @(posedge clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) osc_out_ff <= 1'b0;
        else osc_out_ff <= ~pin_ff[P_OSC];
    end
    assign osc_out_o = osc_out_ff;

    // ==========================================
    // biphase decoder
    dec_state_t  dst_ff;
    logic        sel_ff, ext_ff, half_ff;
    logic [6:0]  tick_ff;
    logic [7:0]  q_ff, nq;
    logic [26:0] dsh_ff;
    logic        line, q_adv, is_a, is_b, in_stop, dec_rej, dec_done;
    logic [31:0] word;
    always_comb begin
        line    = sel_ff ? pin_ff[P_D2] : pin_ff[P_D1];
        nq      = q_ff + 8'h01;
        // bit-time in oscillator periods
        // quarter length
        q_adv   = (dst_ff == D_RUN) && osc_rise && (tick_ff == (ext_ff ? QTR_EXT_M1 : QTR_STD_M1));
        in_stop = nq >= (ext_ff ? QSTOP_EXT : QSTOP_STD);
        is_a    = (nq[1:0] == 2'h3) && !in_stop;
        is_b    = (nq[1:0] == 2'h1) && (nq >= Q_FIRST_B) && !in_stop;
        dec_rej = q_adv && ((is_b && (line == half_ff)) ||
                  ((nq == Q_FIRST_B) && !ext_ff && !half_ff) || (in_stop && !line));
        dec_done = q_adv && !dec_rej && (nq == (ext_ff ? QEND_EXT : QEND_STD));
        word = ext_ff ? {1'b1, 1'b1, sel_ff, dsh_ff, 2'h0}
                      : {1'b1, 1'b0, sel_ff, dsh_ff[11:0], 17'h0};
    end

    always_ff @(posedge clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            dst_ff  <= D_IDLE;
            sel_ff  <= 1'b0;
            ext_ff  <= 1'b0;
            half_ff <= 1'b0;
            tick_ff <= 7'h00;
            q_ff    <= 8'h00;
            dsh_ff  <= 27'h0;
        end else begin
            unique case (dst_ff)
                D_IDLE: begin
                    if (fall1 || fall2) begin
                        sel_ff  <= ~fall1;
                        ext_ff  <= ~fall1 & ~pin_ff[P_FSEL];
                        tick_ff <= 7'h00;
                        q_ff    <= 8'h00;
                        dst_ff  <= D_RUN;
                    end
                end
                D_RUN: begin
                    if (osc_rise) tick_ff <= q_adv ? 7'h00 : tick_ff + 7'h01;
                    if (q_adv) begin
                        q_ff <= nq;
                        if (is_a) half_ff <= line;
                        if (is_b) dsh_ff <= {dsh_ff[25:0], half_ff};
                        if (dec_rej || dec_done) dst_ff <= D_IDLE;
                    end
                end
            endcase
        end
    end

    // ==========================================
    // code buffer and power-off
    i2c_state_t ist_ff;
    logic [31:0] hold_ff;
    logic        hvalid_ff, hext_ff, po_ff, rd_done_ff, accept, po_set, po_clr;
    logic [2:0]  nbytes;
    assign accept = dec_done && (!hvalid_ff || po_ff) && (ist_ff == I_IDLE);
    assign po_set = pin_ff[P_GATE] & ~pin_ff[P_SET];
    assign po_clr = accept && (!ext_ff || (dsh_ff[RSB_POS] &&
                    (dsh_ff[MA_LSB+2:MA_LSB] == pin_ff[P_MA2:P_MA0])));
    assign nbytes = hext_ff ? BYTES_EXT : BYTES_STD;

    always_ff @(posedge clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            hold_ff   <= 32'h0;
            hvalid_ff <= 1'b0;
            hext_ff   <= 1'b0;
        end else if (accept) begin
            hold_ff   <= word;
            hvalid_ff <= 1'b1;
            hext_ff   <= ext_ff;
        end else if (stop_c && rd_done_ff) begin
            hold_ff[31] <= 1'b0;
            hvalid_ff   <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) po_ff <= 1'b0;
        else if (po_set) po_ff <= 1'b1;
        else if (po_clr) po_ff <= 1'b0;
    end
    assign buffer_valid_out_o = hvalid_ff;
    assign power_off_out_o    = po_ff;

    // ==========================================
    // byte buffer between code buffer and shifter
    logic [FIFO_W-1:0]  mem_ff [FIFO_D];
    logic [FIFO_AW-1:0] wp_ff, rp_ff;
    logic [1:0]         cnt_ff;
    logic [2:0]         ld_ff, sent_ff;
    logic [31:0]        wsh;
    logic               in_ready, out_valid, push, pop, ack_go, mack_ff;
    logic [7:0]         ish_ff, txsh_ff;
    logic [3:0]         icnt_ff;
    logic               oe_n_ff;
    assign in_ready  = cnt_ff != FIFO_FULL;
    assign out_valid = cnt_ff != 2'h0;
    assign wsh  = hold_ff << {ld_ff[1:0], 3'h0};
    assign push = (ld_ff < nbytes) && in_ready;
    assign ack_go = scl_fall && !start_c && !stop_c && (ist_ff == I_ADDR) &&
                    (icnt_ff == 4'h8) && (ish_ff == {SLAVE_ADDR, 1'b1});
    assign pop = scl_fall && !start_c && !stop_c && ((ist_ff == I_AACK) ||
                 ((ist_ff == I_MACK) && mack_ff && (sent_ff < nbytes)));

    always_ff @(posedge clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= 2'h0;
            ld_ff  <= LD_IDLE;
        end else if (ack_go) begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= 2'h0;
            ld_ff  <= 3'h0;
        end else begin
            if (push) begin
                wp_ff <= wp_ff + 1'b1;
                ld_ff <= ld_ff + 3'h1;
            end
            if (pop && out_valid) rp_ff <= rp_ff + 1'b1;
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop && out_valid};
        end
    end
    always_ff @(posedge clk_i) begin
        if (push) mem_ff[wp_ff] <= wsh[31:24];
    end

    // ==========================================
    // two-wire slave transmitter
    always_ff @(posedge clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ist_ff     <= I_IDLE;
            ish_ff     <= 8'h00;
            txsh_ff    <= 8'h00;
            icnt_ff    <= 4'h0;
            sent_ff    <= 3'h0;
            mack_ff    <= 1'b0;
            rd_done_ff <= 1'b0;
            oe_n_ff    <= 1'b1;
        end else if (stop_c) begin
            ist_ff  <= I_IDLE;
            oe_n_ff <= 1'b1;
        end else if (start_c) begin
            ist_ff     <= I_ADDR;
            icnt_ff    <= 4'h0;
            rd_done_ff <= 1'b0;
            oe_n_ff    <= 1'b1;
        end else if (pop) begin
            txsh_ff <= mem_ff[rp_ff];
            oe_n_ff <= mem_ff[rp_ff][7];
            icnt_ff <= 4'h0;
            sent_ff <= sent_ff + 3'h1;
            if (sent_ff + 3'h1 == nbytes) rd_done_ff <= 1'b1;
            ist_ff  <= I_TX;
        end else begin
            unique case (ist_ff)
                I_IDLE: ;
                I_ADDR: begin
                    if (scl_rise) begin
                        ish_ff  <= {ish_ff[6:0], pin_ff[P_SDA]};
                        icnt_ff <= icnt_ff + 4'h1;
                    end else if (scl_fall && icnt_ff == 4'h8) begin
                        oe_n_ff <= ~ack_go;
                        sent_ff <= 3'h0;
                        ist_ff  <= ack_go ? I_AACK : I_WAIT;
                    end
                end
                I_AACK: ;
                I_TX: begin
                    if (scl_fall) begin
                        if (icnt_ff == 4'h7) begin
                            oe_n_ff <= 1'b1;
                            ist_ff  <= I_MACK;
                        end else begin
                            txsh_ff <= {txsh_ff[6:0], 1'b0};
                            oe_n_ff <= txsh_ff[6];
                            icnt_ff <= icnt_ff + 4'h1;
                        end
                    end
                end
                I_MACK: begin
                    if (scl_rise) mack_ff <= ~pin_ff[P_SDA];
                    else if (scl_fall) ist_ff <= I_WAIT;
                end
                I_WAIT: ;
            endcase
        end
    end
    assign sda_o      = 1'b0;
    assign sda_oe_n_o = oe_n_ff;

    // ==========================================
    // assertions
    a_po_standby: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        po_set |=> po_ff) else $error("power-off not raised");
    a_po_gate_off: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        (!pin_ff[P_GATE] && !po_ff) |=> !po_ff) else $error("standby not gated");
    a_po_std_clear: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        (accept && !ext_ff && !po_set) |=> !po_ff) else $error("power-off kept");
    a_po_ext_keep: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        (accept && ext_ff && !dsh_ff[RSB_POS] && po_ff) |=> po_ff)
        else $error("power-off dropped");
    a_discard_full: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        (dec_done && hvalid_ff && !po_ff && !stop_c) |=> $stable(hold_ff))
        else $error("full buffer overwritten");
    a_reject_frame: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        dec_rej |=> (dst_ff == D_IDLE) && $stable(hold_ff))
        else $error("rejected frame stored");
    a_input_locked: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        (dst_ff == D_RUN) |=> $stable(sel_ff) && $stable(ext_ff))
        else $error("input switched in frame");
    a_addr_ack: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        ack_go |=> (ist_ff == I_AACK) && !sda_oe_n_o) else $error("no address ack");
    a_write_nack: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        (scl_fall && !start_c && !stop_c && ist_ff == I_ADDR && icnt_ff == 4'h8 &&
         ish_ff[0] == 1'b0) |=> (ist_ff == I_WAIT) && sda_oe_n_o)
        else $error("write not refused");
    a_wait_release: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        (ist_ff == I_WAIT) |-> sda_oe_n_o) else $error("line held while waiting");
    a_msb_first: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        (pop && out_valid) |=> sda_oe_n_o == $past(mem_ff[rp_ff][7]))
        else $error("first bit not msb");
    a_read_empties: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
        (stop_c && rd_done_ff && !accept) |=> !buffer_valid_out_o)
        else $error("buffer not emptied");
    c_std_word: cover property (@(posedge clk_i) accept && !ext_ff);
    c_ext_word: cover property (@(posedge clk_i) accept && ext_ff);
    c_full_read: cover property (@(posedge clk_i) stop_c && rd_done_ff);
    c_write_refused: cover property (@(posedge clk_i) ist_ff == I_WAIT && !rd_done_ff);
endmodule // ir_transcoder

/* test/i2c_master_model.sv */
// two-wire bus master model that reads decoded words from the transcoder
`timescale 1ns/100ps
module i2c_master_model (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    // ==========================================================
    // bus idles released, clock high
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    // ==========================================================
    // bit timing, one quarter of the 80 ns bus clock
    task automatic qtr(int n);
        repeat (4 * n) @(posedge clk_i);
    endtask

    task automatic put(logic v);
        sda_low_o <= ~v;
        qtr(1);
        scl_o <= 1'b1;
        qtr(2);
        scl_o <= 1'b0;
        qtr(1);
    endtask

    // released line floats to the pull-up; sampled mid-high
    task automatic get(output logic v);
        sda_low_o <= 1'b0;
        qtr(1);
        scl_o <= 1'b1;
        qtr(1);
        #1 v = sda_i;
        qtr(1);
        scl_o <= 1'b0;
        qtr(1);
    endtask

    // ==========================================================
    // one read transaction
    task automatic xfer(input  logic [7:0]  ab,
                        input  int          nb,
                        input  int          na,
                        output logic        ack,
                        output logic [31:0] got);
        logic v;
        int   m;
        m = 0;
        got = 32'h0;
        sda_low_o <= 1'b1;
        qtr(1);
        scl_o <= 1'b0;
        qtr(1);
        for (int i = 7; i >= 0; i--)
            put(ab[i]);
        get(v);
        ack = ~v;
        for (int k = 0; k < nb && ack; k++) begin
            for (int i = 0; i < 8; i++) begin
                get(v);
                got = {got[30:0], v};
            end
            m++;
            // acknowledge the first na bytes, refuse the next one and stop
            put(k >= na);
            if (k >= na)
                break;
        end
        // left align the bytes actually read
        if (m > 0)
            got = got << (32 - 8 * m);
        sda_low_o <= 1'b1;
        qtr(1);
        scl_o <= 1'b1;
        qtr(1);
        sda_low_o <= 1'b0;
        qtr(2);
    endtask
endmodule // i2c_master_model

/* test/tb.sv */
// self-checking bench for the infrared transcoder
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb;
    import ir_pkg::*;
    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        osc = 1'b0;
    logic        d1 = 1'b1;
    logic        d2 = 1'b1;
    logic        fsel = 1'b1;
    logic        gate = 1'b0;
    logic        sset = 1'b1;
    logic [2:0]  ma = 3'h0;
    logic        scl, sda_low, sda_o, sda_oe_n, valid, po, ack, oscq;
    int          n_oi = 0;
    int          n_oo = 0;
    logic [31:0] rs = 32'h00015601;
    logic [31:0] e, x, got, v;
    logic [26:0] b, bb;
    int          mismatches = 0;
    int          n_checks = 0;
    int          cyc = 0;
    wire         sda = sda_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_o);
    localparam logic [7:0] RD = {SLAVE_ADDR, 1'b1};

    always #2.5 clk_i = ~clk_i;
    always #8.15 osc = ~osc;
    always @(negedge osc) n_oi++;
    always @(posedge oscq) n_oo++;

    ir_transcoder u_ir_transcoder (.clk_i(clk_i), .rstn_i(rstn_i), .data1_i(d1), .data2_i(d2),
        .format_select_in_i(fsel), .master_addr_in0_i(ma[0]), .master_addr_in1_i(ma[1]),
        .master_addr_in2_i(ma[2]), .standby_gate_in_i(gate), .standby_set_in_i(sset),
        .osc_in_i(osc), .scl_i(scl), .sda_i(sda), .osc_out_o(oscq), .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n), .buffer_valid_out_o(valid), .power_off_out_o(po));
    i2c_master_model u_i2c_master_model (.clk_i(clk_i), .sda_i(sda), .scl_o(scl),
        .sda_low_o(sda_low));

    // ==========================================================
    // helpers
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 95000) begin
            mismatches++;
            close_out();
        end
    end

    function automatic logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    // second start bit forced to one
    function automatic logic [26:0] rnd_std();
        logic [31:0] r;
        r = xs();
        return {14'h0, 1'b1, r[11:0]};
    endfunction
    function automatic logic [31:0] exp_word(logic ext, logic inp, logic [26:0] w);
        return ext ? {2'h3, inp, w, 2'h0} : {2'h2, inp, w[11:0], 17'h0};
    endfunction

    task automatic clks(int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic pin(int ch, logic lv);
        if (ch == 1)
            d1 <= lv;
        else
            d2 <= lv;
    endtask
    task automatic wosc(int n);
        repeat (n) @(posedge osc);
        @(posedge clk_i);
    endtask
    // mark is low; bit value is the first-half level
    task automatic send(int ch, int n, logic [26:0] w, bit bad);
        int h;
        h = (n == N_STD) ? OSC_PER_BIT_STD / 2 : OSC_PER_BIT_EXT / 2;
        @(posedge clk_i);
        pin(ch, 1'b0);
        wosc(h);
        for (int i = n - 1; i >= 0; i--) begin
            pin(ch, w[i]);
            wosc(h);
            pin(ch, (bad && i == 2) ? w[i] : ~w[i]);
            wosc(h);
        end
        pin(ch, 1'b1);
        wosc(5 * h);
    endtask
    task automatic frame(int ch, bit ext, logic [26:0] w, bit bad, output logic [31:0] ex);
        send(ch, ext ? N_EXT : N_STD, w, bad);
        clks(20);
        ex = exp_word(ext, ch == 2, w);
    endtask
    task automatic rd(logic [7:0] ab, int nb, int na, output logic ak, output logic [31:0] g);
        u_i2c_master_model.xfer(ab, nb, na, ak, g);
        clks(6);
    endtask
    task automatic stby(logic g);
        gate <= g;
        sset <= 1'b0;
        clks(10);
        sset <= 1'b1;
        clks(10);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        clks(4);
        rstn_i <= 1'b1;
        clks(12);
        `CHK("valid_rst", 1'b0, valid)
        `CHK("po_rst", 1'b0, po)
        v = xs();
        ma <= v[2:0];
        frame(1, 0, rnd_std(), 0, e);
        `CHK("f1_valid", 1'b1, valid)
        rd(RD, 2, 1, ack, got);
        `CHK("f1_word", e, got)
        `CHK("f1_empty", 1'b0, valid)
        fsel <= 1'b0;
        frame(1, 1, 27'(xs()), 0, x);
        `CHK("ext_on_in1", 1'b0, valid)
        frame(2, 0, rnd_std(), 0, x);
        `CHK("std_on_in2", 1'b0, valid)
        frame(1, 0, rnd_std(), 1, x);
        `CHK("bad_biphase", 1'b0, valid)
        stby(0);
        `CHK("po_gated", 1'b0, po)
        stby(1);
        `CHK("po_set", 1'b1, po)
        b = rnd_std();
        bb = rnd_std();
        fork
            send(1, N_STD, b, 0);
            begin
                wosc(8);
                send(2, N_STD, bb, 0);
            end
        join
        clks(20);
        e = exp_word(0, 0, b);
        `CHK("po_std_clear", 1'b0, po)
        fsel <= 1'b1;
        frame(2, 0, rnd_std(), 0, x);
        rd(RD, 2, 0, ack, got);
        `CHK("kept_byte", e[31:24], got[31:24])
        `CHK("first_input", 1'b0, got[29])
        `CHK("nack_keeps", 1'b1, valid)
        rd({SLAVE_ADDR, 1'b0}, 2, 1, ack, got);
        `CHK("write_nack", 1'b0, ack)
        rd(8'h4F, 2, 1, ack, got);
        `CHK("other_addr", 1'b0, ack)
        fsel <= 1'b0;
        stby(1);
        v = xs();
        frame(2, 1, {~ma, v[23:17], 1'b1, v[15:0]}, 0, e);
        `CHK("po_mismatch", 1'b1, po)
        rd(RD, 4, 3, ack, got);
        `CHK("overwrite", e, got)
        v = xs();
        frame(2, 1, {ma, v[23:17], 1'b1, v[15:0]}, 0, e);
        `CHK("po_match", 1'b0, po)
        rd(RD, 4, 3, ack, got);
        `CHK("ext_word", e, got)
        `CHK("osc_out", 1'b1, 1'((n_oi - n_oo) <= 2 && n_oo > 0))
        close_out();
    end
endmodule // tb
